// file: dram_timing_cfg.svh
/*
 Register indexes, field positions, reset values and write masks for the
 display memory timing and refresh controller. Assumes 8-bit indexed access.
*/
`ifndef DRAM_TIMING_CFG_SVH
`define DRAM_TIMING_CFG_SVH

`define IDX_ROW_STROBE_TIMING 8'h26
`define IDX_COLUMN_STROBE_TIMING 8'h27
`define IDX_REFRESH_SETUP 8'h28
`define IDX_DISPLAY_FETCH_BURST 8'h29
`define IDX_MODE_SELECT 8'h21
`define IDX_FIFO_DEPTH 8'h20

`define RST_ROW_STROBE_TIMING 8'h01
`define RST_COLUMN_STROBE_TIMING 8'h10
`define RST_REFRESH_SETUP 8'h03
`define RST_DISPLAY_FETCH_BURST 8'h04
`define RST_MODE_SELECT 8'h00
`define RST_FIFO_DEPTH 8'h81

`define MASK_ROW_STROBE_TIMING 8'h0B
`define MASK_COLUMN_STROBE_TIMING 8'h37
`define MASK_REFRESH_SETUP 8'h0B
`define MASK_DISPLAY_FETCH_BURST 8'h07
`define MASK_FIFO_DEPTH 8'hCF

`define ROW_PRECHARGE_LSB 0
`define ROW_HALF_BIT 3
`define COL_PRECHARGE_BIT 0
`define COL_HALF_BIT 1
`define COL_PULSE_BIT 2
`define ROW_TO_COL_LSB 4
`define REFRESH_COUNT_LSB 0
`define REFRESH_TYPE_BIT 3
`define SYNC_MODE_BIT 7

`define SEQ_RESET_INDEX 8'h00
`define SEQ_RESET_RUN 8'h03

`endif

// file: dram_timing_pkg.sv
/*
 Types for the display memory timing controller.
 Assumes the cfg header supplies all numeric constants.
*/
package dram_timing_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PRE_ENTRY = 7'h02,
        ST_PRE_HOLD = 7'h04,
        ST_ROW_TO_COL = 7'h08,
        ST_COL_PRE = 7'h10,
        ST_COL_PULSE = 7'h20,
        ST_CBR = 7'h40
    } cycle_state_type;

    typedef enum logic [2:0] {
        REQ_NONE = 3'h1,
        REQ_DISPLAY = 3'h2,
        REQ_REFRESH = 3'h4,
        REQ_HOST = 3'h0
    } requester_type;

    typedef struct packed {
        logic row_strobe_n;
        logic column_strobe_n;
        logic row_half_early;
        logic column_half_early;
    } strobe_bus_type;

    typedef struct packed {
        logic write;
        logic [7:0] index;
        logic [7:0] data;
    } reg_access_type;

endpackage

// file: refresh_pacer.sv
/*
 Refresh pacer: counts refresh cycles owed per scan line.
 Assumes line_start_in is a one-cycle pulse in the clk_sys_in domain.
*/
`timescale 1ns/100ps
`include "dram_timing_cfg.svh"

module refresh_pacer
    import dram_timing_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Setup
    input wire logic [1:0] refresh_count_in,
    input wire logic legacy_refresh_select_in,
    // Handshake
    input wire logic line_start_in,
    input wire logic refresh_done_in,
    output logic refresh_request_out
);

    logic [2:0] owed_reg;
    logic [2:0] per_line;

    // Legacy select: clear gives 3 cycles, set gives 5
    always_comb
    begin
        unique case (refresh_count_in)
            2'h1: per_line = 3'h1;
            2'h2: per_line = 3'h2;
            2'h3: per_line = legacy_refresh_select_in ? 3'h5 : 3'h3;
            default: per_line = 3'h0;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            owed_reg <= 3'h0;
        else if (line_start_in)
            owed_reg <= per_line;
        else if (refresh_done_in && owed_reg != 3'h0)
            owed_reg <= owed_reg - 3'h1;
    end

    assign refresh_request_out = (owed_reg != 3'h0);

endmodule // refresh_pacer

// file: dram_timing_ctrl.sv
/*
 Display memory DRAM cycle sequencer with indexed timing registers.
 Assumes host I/O decode presents index/data writes already resolved,
 all request inputs are on clk_sys_in (the memory clock), and a half-clock
 phase is realised by strobe pads using the *_half_early outputs.
*/
`timescale 1ns/100ps
`include "dram_timing_cfg.svh"

// Operation
// - Row precharge is one entry state plus 1 to 4 hold states, giving 2 to 5 clocks.
// - Row half-clock bit trims precharge and widens the row pulse by half a clock.
// - Row active width is row-to-column delay plus column precharge plus pulse width.
// - Column precharge is one clock; the other code is reserved and not used.
// - Column half-clock bit trims column precharge and widens the pulse by half a clock.
// - Column pulse is one or two pulse states as the pulse bit says.
// - Row-to-column states number 1 to 4 from the two-bit delay field.
// - Reset timing is 3 clocks row precharge, 1 column precharge and pulse, 2 delay.
// - Refresh field gives none, 1 or 2 cycles per line or follows the legacy select.
// - Refresh type selects column-before-row or row-only refresh; register resets to 03h.
// - Each display fetch is a burst of 4, 8, 16 or 32 back-to-back accesses.
// - Synchronous mode bit is held but not implemented; logic runs asynchronously.
// - Display FIFO level at or below the threshold in graphics mode makes display fetch win the bus.
module dram_timing_ctrl
    import dram_timing_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Indexed register port
    input wire reg_access_type reg_access_in,
    input wire logic reg_strobe_in,
    input wire logic [7:0] reg_read_index_in,
    output logic [7:0] reg_read_data_out,
    input wire logic sequencer_reset_held_in,
    // Display and CRT side
    input wire logic line_start_in,
    input wire logic legacy_refresh_select_in,
    input wire logic graphics_mode_in,
    input wire logic [3:0] fifo_level_in,
    input wire logic display_request_in,
    input wire logic host_request_in,
    input wire logic wide_bus_in,
    // Memory side
    output strobe_bus_type strobe_out,
    output logic access_strobe_out,
    output logic [2:0] grant_out,
    output logic refresh_active_out,
    output logic [5:0] burst_remaining_out,
    output logic wide_access_out,
    output logic sync_mode_out
);

    logic [7:0] row_strobe_timing_reg;
    logic [7:0] column_strobe_timing_reg;
    logic [7:0] refresh_setup_reg;
    logic [7:0] display_fetch_burst_reg;
    logic [7:0] mode_select_reg;
    logic [7:0] fifo_depth_reg;
    cycle_state_type state_reg;
    cycle_state_type state_next;
    requester_type owner_reg;
    logic [2:0] count_reg;
    logic [5:0] burst_reg;
    logic refresh_request;
    logic refresh_done;
    logic display_urgent;
    logic wr;

    function automatic logic [5:0] burst_len(input logic [2:0] code);
        unique case (code[1:0])
            2'h0: burst_len = 6'h04;
            2'h1: burst_len = 6'h08;
            2'h2: burst_len = 6'h10;
            default: burst_len = 6'h20;
        endcase
    endfunction

    // Row strobe low in the state about to be entered
    function automatic logic row_active(input cycle_state_type st, input requester_type who);
        row_active = (st == ST_ROW_TO_COL) || (st == ST_CBR)
            || ((st == ST_COL_PRE || st == ST_COL_PULSE) && who != REQ_REFRESH);
    endfunction

    // Column strobe low, including the column-first refresh state
    function automatic logic column_active(input cycle_state_type st,
        input requester_type who, input logic row_only);
        column_active = (st == ST_COL_PULSE)
            || (who == REQ_REFRESH && !row_only && st == ST_CBR);
    endfunction

    // Write qualified by the strobe
    assign wr = reg_strobe_in && reg_access_in.write;

    // Timing registers, reserved bits kept zero
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            row_strobe_timing_reg <= `RST_ROW_STROBE_TIMING;
            column_strobe_timing_reg <= `RST_COLUMN_STROBE_TIMING;
            refresh_setup_reg <= `RST_REFRESH_SETUP;
            display_fetch_burst_reg <= `RST_DISPLAY_FETCH_BURST;
            fifo_depth_reg <= `RST_FIFO_DEPTH;
        end
        else if (wr)
        begin
            unique case (reg_access_in.index)
                `IDX_ROW_STROBE_TIMING:
                    row_strobe_timing_reg <= reg_access_in.data & `MASK_ROW_STROBE_TIMING;
                `IDX_COLUMN_STROBE_TIMING:
                    column_strobe_timing_reg <= reg_access_in.data & `MASK_COLUMN_STROBE_TIMING;
                `IDX_REFRESH_SETUP:
                    refresh_setup_reg <= reg_access_in.data & `MASK_REFRESH_SETUP;
                `IDX_DISPLAY_FETCH_BURST:
                    display_fetch_burst_reg <= reg_access_in.data & `MASK_DISPLAY_FETCH_BURST;
                `IDX_FIFO_DEPTH:
                    fifo_depth_reg <= reg_access_in.data & `MASK_FIFO_DEPTH;
                default:
                    row_strobe_timing_reg <= row_strobe_timing_reg;
            endcase
        end
    end

    // Clock mode only accepted under sequencer reset
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            mode_select_reg <= `RST_MODE_SELECT;
        else if (wr && reg_access_in.index == `IDX_MODE_SELECT && sequencer_reset_held_in)
            mode_select_reg <= reg_access_in.data;
    end

    // Read mux; unmapped indexes read zero
    always_comb
    begin
        unique case (reg_read_index_in)
            `IDX_ROW_STROBE_TIMING: reg_read_data_out = row_strobe_timing_reg;
            `IDX_COLUMN_STROBE_TIMING: reg_read_data_out = column_strobe_timing_reg;
            `IDX_REFRESH_SETUP: reg_read_data_out = refresh_setup_reg;
            `IDX_DISPLAY_FETCH_BURST: reg_read_data_out = display_fetch_burst_reg;
            `IDX_MODE_SELECT: reg_read_data_out = mode_select_reg;
            `IDX_FIFO_DEPTH: reg_read_data_out = fifo_depth_reg;
            default: reg_read_data_out = 8'h00;
        endcase
    end

    // Synchronous mode not built; memory logic stays on the memory clock
    assign sync_mode_out = mode_select_reg[`SYNC_MODE_BIT];

    refresh_pacer u_pacer (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .refresh_count_in(refresh_setup_reg[`REFRESH_COUNT_LSB +: 2]),
        .legacy_refresh_select_in(legacy_refresh_select_in),
        .line_start_in(line_start_in),
        .refresh_done_in(refresh_done),
        .refresh_request_out(refresh_request)
    );

    assign display_urgent = graphics_mode_in && display_request_in
        && (fifo_level_in <= fifo_depth_reg[3:0]);

    // Next state; precharge states reload count
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (display_urgent || refresh_request || host_request_in
                    || display_request_in)
                    state_next = ST_PRE_ENTRY;
            ST_PRE_ENTRY:
                state_next = ST_PRE_HOLD;
            ST_PRE_HOLD:
                if (count_reg == 3'h0)
                    state_next = (owner_reg == REQ_REFRESH) ?
                        (refresh_setup_reg[`REFRESH_TYPE_BIT] ? ST_CBR : ST_COL_PRE)
                        : ST_ROW_TO_COL;
            ST_ROW_TO_COL:
                if (count_reg == 3'h0)
                    state_next = ST_COL_PRE;
            ST_COL_PRE:
                state_next = ST_COL_PULSE;
            ST_COL_PULSE:
                if (count_reg == 3'h0)
                    state_next = (owner_reg == REQ_DISPLAY && burst_reg > 6'h1) ?
                        ST_COL_PRE : (owner_reg == REQ_REFRESH ? ST_CBR : ST_IDLE);
            ST_CBR:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Cycle state register
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Per-state counter: loaded on entry, counts down
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            count_reg <= 3'h0;
        else if (state_next != state_reg || state_next == ST_COL_PRE)
        begin
            unique case (state_next)
                ST_PRE_HOLD:
                    count_reg <= {1'b0, row_strobe_timing_reg[`ROW_PRECHARGE_LSB +: 2]};
                ST_ROW_TO_COL:
                    count_reg <= {1'b0, column_strobe_timing_reg[`ROW_TO_COL_LSB +: 2]};
                ST_COL_PULSE:
                    count_reg <= {2'h0, column_strobe_timing_reg[`COL_PULSE_BIT]};
                default:
                    count_reg <= 3'h0;
            endcase
        end
        else if (count_reg != 3'h0)
            count_reg <= count_reg - 3'h1;
    end

    // Arbitration at idle: urgent display, refresh, host, display
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            owner_reg <= REQ_NONE;
        else if (state_reg == ST_IDLE && state_next == ST_PRE_ENTRY)
        begin
            if (display_urgent)
                owner_reg <= REQ_DISPLAY;
            else if (refresh_request)
                owner_reg <= REQ_REFRESH;
            else if (host_request_in)
                owner_reg <= REQ_HOST;
            else
                owner_reg <= REQ_DISPLAY;
        end
        else if (state_next == ST_IDLE)
            owner_reg <= REQ_NONE;
    end

    // Burst counter for display fetches
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            burst_reg <= 6'h00;
        else if (state_reg == ST_IDLE)
            burst_reg <= burst_len(display_fetch_burst_reg[2:0]);
        else if (state_reg == ST_COL_PULSE && count_reg == 3'h0 && burst_reg != 6'h0)
            burst_reg <= burst_reg - 6'h1;
    end

    // Refresh counted once per completed cycle
    assign refresh_done = (state_reg == ST_CBR);

    // Registered strobes; row active spans delay, column precharge and pulse
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            strobe_out <= '{1'b1, 1'b1, 1'b0, 1'b0};
        end
        else
        begin
            // Row low from row-to-column through last pulse
            strobe_out.row_strobe_n <= !row_active(state_next, owner_reg);
            // Column before row on refresh when type bit clear
            strobe_out.column_strobe_n <= !column_active(state_next, owner_reg,
                refresh_setup_reg[`REFRESH_TYPE_BIT]);
            strobe_out.row_half_early <= row_strobe_timing_reg[`ROW_HALF_BIT];
            strobe_out.column_half_early <= column_strobe_timing_reg[`COL_HALF_BIT];
        end
    end

    // Access pulse, bus width and refresh flag
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            access_strobe_out <= 1'b0;
            wide_access_out <= 1'b0;
            refresh_active_out <= 1'b0;
        end
        else
        begin
            access_strobe_out <= (state_next == ST_COL_PULSE && state_reg != ST_COL_PULSE);
            wide_access_out <= wide_bus_in;
            refresh_active_out <= (owner_reg == REQ_REFRESH);
        end
    end

    // Owner and burst count straight from registers
    assign grant_out = owner_reg;
    assign burst_remaining_out = burst_reg;

endmodule // dram_timing_ctrl

// file: dram_timing_ctrl_assertions.sv
/*
 Checker for the display memory timing controller.
 Assumes it is bound to dram_timing_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
module dram_timing_ctrl_assertions
    import dram_timing_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register port
    input wire reg_access_type reg_access_in,
    input wire logic reg_strobe_in,
    input wire logic [7:0] reg_read_index_in,
    input wire logic [7:0] reg_read_data_out,
    input wire logic sequencer_reset_held_in,
    // Memory side
    input wire strobe_bus_type strobe_out,
    input wire logic access_strobe_out,
    input wire logic [2:0] grant_out,
    input wire logic [5:0] burst_remaining_out,
    input wire logic sync_mode_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    logic mode_wr;
    logic row_wr;
    assign mode_wr = reg_strobe_in && reg_access_in.write && reg_access_in.index == 8'h21;
    assign row_wr = reg_strobe_in && reg_access_in.write && reg_access_in.index == 8'h26;
    sequence s_row_rest;
        strobe_out.row_strobe_n [*2];
    endsequence
    sequence s_pulse_once;
        !strobe_out.column_strobe_n ##1 !access_strobe_out;
    endsequence
    a_reset_idle: assert property ($fell(reset_in) |-> grant_out == 3'h1
        && strobe_out.row_strobe_n && strobe_out.column_strobe_n && !sync_mode_out)
        else $error("outputs not idle after reset");
    a_grant_legal: assert property (grant_out inside {3'h0, 3'h1, 3'h2, 3'h4})
        else $error("grant code illegal");
    a_owner_via_idle: assert property ($changed(grant_out) |->
        grant_out == 3'h1 || $past(grant_out) == 3'h1)
        else $error("grant passed without idle");
    a_access_in_pulse: assert property (access_strobe_out |-> s_pulse_once)
        else $error("access strobe outside column pulse");
    a_access_granted: assert property (access_strobe_out |-> grant_out != 3'h1)
        else $error("access with no owner");
    a_precharge_min: assert property ($rose(strobe_out.row_strobe_n) |-> s_row_rest)
        else $error("row precharge too short");
    a_mode_refused: assert property (mode_wr && !sequencer_reset_held_in |=>
        $stable(sync_mode_out))
        else $error("mode changed while running");
    a_mode_taken: assert property (mode_wr && sequencer_reset_held_in |=>
        sync_mode_out == $past(reg_access_in.data[7]))
        else $error("mode write lost");
    a_row_readback: assert property (row_wr ##2 reg_read_index_in == 8'h26 |->
        reg_read_data_out == ($past(reg_access_in.data, 2) & 8'h0B))
        else $error("row timing readback wrong");
    a_burst_bound: assert property (burst_remaining_out <= 6'h20)
        else $error("burst count above 32");
endmodule // dram_timing_ctrl_assertions

bind dram_timing_ctrl dram_timing_ctrl_assertions checker_inst (.clk_sys_in, .reset_in,
    .reg_access_in, .reg_strobe_in, .reg_read_index_in, .reg_read_data_out,
    .sequencer_reset_held_in, .strobe_out, .access_strobe_out, .grant_out,
    .burst_remaining_out, .sync_mode_out);

// file: dram_array_model.sv
/*
 DRAM stand-in: measures strobe widths and counts refresh cycles.
 Assumes strobes change only on the memory clock.
*/
`timescale 1ns/100ps
module dram_array_model
    import dram_timing_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Strobes from the controller
    input wire strobe_bus_type strobe_in,
    // Measurements
    output int row_low_out = 0,
    output int col_low_out = 0,
    output int half_out = 0,
    output int row_falls_out = 0,
    output int cbr_out = 0
);
    int row_run = 0;
    int col_run = 0;
    strobe_bus_type last = '1;
    always @(posedge clk_sys_in)
    begin
        row_run = strobe_in.row_strobe_n ? 0 : row_run + 1;
        col_run = strobe_in.column_strobe_n ? 0 : col_run + 1;
        if (!strobe_in.row_strobe_n)
            row_low_out = row_run;
        if (!strobe_in.column_strobe_n)
            col_low_out = col_run;
        if (last.row_strobe_n && !strobe_in.row_strobe_n)
            row_falls_out++;
        // Column falling under an idle row is a refresh
        if (last.column_strobe_n && !strobe_in.column_strobe_n && strobe_in.row_strobe_n)
            cbr_out++;
        if (strobe_in.row_half_early || strobe_in.column_half_early)
            half_out++;
        last = strobe_in;
    end
endmodule // dram_array_model

// file: test_dram_timing_ctrl.sv
/*
 Self-checking bench for the display memory timing controller.
 Assumes the DRAM stand-in and the bound checker compile alongside.
*/
`timescale 1ns/100ps
`include "dram_timing_cfg.svh"
module test_dram_timing_ctrl;
    import dram_timing_pkg::*;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    reg_access_type reg_access_in = '0;
    logic reg_strobe_in = 1'b0;
    logic [7:0] reg_read_index_in = 8'h00;
    logic [7:0] reg_read_data_out;
    logic sequencer_reset_held_in = 1'b0;
    logic line_start_in = 1'b0;
    logic legacy_refresh_select_in = 1'b0;
    logic graphics_mode_in = 1'b0;
    logic [3:0] fifo_level_in = 4'hF;
    logic display_request_in = 1'b0;
    logic host_request_in = 1'b0;
    logic wide_bus_in = 1'b0;
    strobe_bus_type strobe_out;
    logic access_strobe_out;
    logic [2:0] grant_out;
    logic refresh_active_out;
    logic [5:0] burst_remaining_out;
    logic wide_access_out;
    logic sync_mode_out;
    int row_low, col_low, half_cnt, row_falls, cbr_cnt;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] masks [4] = '{`MASK_ROW_STROBE_TIMING, `MASK_COLUMN_STROBE_TIMING,
        `MASK_REFRESH_SETUP, `MASK_DISPLAY_FETCH_BURST};
    always #5 clk_sys_in = ~clk_sys_in;
    dram_timing_ctrl dut (.clk_sys_in, .reset_in, .reg_access_in, .reg_strobe_in,
        .reg_read_index_in, .reg_read_data_out, .sequencer_reset_held_in, .line_start_in,
        .legacy_refresh_select_in, .graphics_mode_in, .fifo_level_in, .display_request_in,
        .host_request_in, .wide_bus_in, .strobe_out, .access_strobe_out, .grant_out,
        .refresh_active_out, .burst_remaining_out, .wide_access_out, .sync_mode_out);
    dram_array_model chips (.clk_sys_in, .strobe_in(strobe_out), .row_low_out(row_low),
        .col_low_out(col_low), .half_out(half_cnt), .row_falls_out(row_falls),
        .cbr_out(cbr_cnt));
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic fail(input string msg);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
            fail($sformatf("got %h expected %h", got, exp));
    endtask
    task automatic check_count(input int got, input int exp);
        tests_run++;
        if (got != exp)
            fail($sformatf("count %0d expected %0d", got, exp));
    endtask
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
        reg_access_in = {1'b1, idx, data};
        reg_strobe_in = 1'b1;
        tick();
        reg_strobe_in = 1'b0;
        tick();
    endtask
    task automatic read_check(input logic [7:0] idx, input logic [7:0] exp);
        reg_read_index_in = idx;
        #1;
        check_byte(reg_read_data_out, exp);
    endtask
    task automatic wait_grant(input logic [2:0] g);
        int n;
        n = 0;
        while (grant_out !== g && n < 800)
        begin
            tick();
            n++;
        end
        if (n == 800)
            fail("grant wait ran out");
    endtask
    function automatic int refresh_expect(input int code, input logic legacy);
        return code == 1 ? 1 : code == 2 ? 2 : legacy ? 5 : 3;
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #500000;
        fail("watchdog expired");
        final_report();
    end
    initial
    begin
        logic [7:0] d;
        logic [1:0] dl;
        logic pl, hl;
        int c, n, base, cb;
        void'($urandom(73));
        repeat (5) tick();
        reset_in = 1'b0;
        tick();
        read_check(8'h26, 8'h01);
        read_check(8'h27, 8'h10);
        read_check(8'h28, 8'h03);
        read_check(8'h29, 8'h04);
        read_check(8'h5A, 8'h00);
        for (c = 0; c < 4; c++)
        begin
            d = 8'($urandom);
            if (c == 1)
                d[0] = 1'b0;
            if (c == 2 && d[1:0] == 2'b00)
                d[0] = 1'b1;
            write_reg(8'h26 + 8'(c), d);
            read_check(8'h26 + 8'(c), d & masks[c]);
        end
        write_reg(8'h21, 8'h80);
        check_byte({7'h00, sync_mode_out}, 8'h00);
        sequencer_reset_held_in = 1'b1;
        write_reg(8'h21, 8'h80);
        check_byte({7'h00, sync_mode_out}, 8'h01);
        write_reg(8'h21, 8'h00);
        sequencer_reset_held_in = 1'b0;
        $display("registers done");
        for (c = 0; c < 12; c++)
        begin
            dl = 2'($urandom);
            pl = 1'($urandom);
            hl = 1'($urandom);
            wide_bus_in = 1'($urandom);
            fifo_level_in = 4'($urandom);
            write_reg(8'h26, {4'h0, hl, 1'b0, 2'($urandom)});
            write_reg(8'h27, {2'b00, dl, 1'b0, pl, hl, 1'b0});
            base = half_cnt;
            host_request_in = 1'b1;
            wait_grant(3'h0);
            host_request_in = 1'b0;
            wait_grant(3'h1);
            tick();
            check_count(row_low, dl + pl + 3);
            check_count(col_low, pl + 1);
            check_count(int'(half_cnt > base), int'(hl));
        end
        $display("host cycles done");
        for (c = 0; c < 4; c++)
        begin
            n = c < 3 ? c + 1 : 3;
            legacy_refresh_select_in = c == 3;
            write_reg(8'h28, {4'h0, c[0], 1'b0, 2'(n)});
            base = row_falls;
            cb = cbr_cnt;
            line_start_in = 1'b1;
            tick();
            line_start_in = 1'b0;
            repeat (200) tick();
            n = refresh_expect(n, legacy_refresh_select_in);
            check_count(row_falls - base, n);
            check_count(cbr_cnt - cb, c[0] ? 0 : n);
        end
        $display("refresh done");
        for (c = 0; c < 4; c++)
        begin
            wide_bus_in = c[0];
            write_reg(8'h29, 8'(c));
            display_request_in = 1'b1;
            wait_grant(3'h2);
            display_request_in = 1'b0;
            n = 0;
            base = 0;
            while (grant_out !== 3'h1 && base < 800)
            begin
                if (access_strobe_out === 1'b1)
                    n++;
                tick();
                base++;
            end
            check_count(n, 4 << c);
            check_byte({2'b00, burst_remaining_out}, 8'h00);
            check_byte({7'h00, wide_access_out}, {7'h00, wide_bus_in});
        end
        $display("display fetch done");
        graphics_mode_in = 1'b1;
        for (c = 0; c < 2; c++)
        begin
            fifo_level_in = c ? 4'hF : 4'h0;
            line_start_in = 1'b1;
            tick();
            line_start_in = 1'b0;
            display_request_in = 1'b1;
            tick();
            display_request_in = 1'b0;
            check_byte({5'h00, grant_out}, c ? 8'h04 : 8'h02);
            tick();
            check_byte({7'h00, refresh_active_out}, 8'(c));
            repeat (250) tick();
        end
        graphics_mode_in = 1'b0;
        $display("arbitration done");
        final_report();
    end
endmodule // test_dram_timing_ctrl
